/* File: mac_engine.sv */
// Signed 16x16 multiply-accumulate engine with a 40-bit accumulator,
// one-bit accumulator shifter and a registered rounding result.
// Assumes byte write strobes from the core on the same clock, one per cycle at most.
//
// Notes on behaviour
// - Fractional bit low: integer operands and result.
// - Fractional bit high: product realigned to Q31.
// - Accumulate mode adds product to accumulator.
// - Operand B low write starts an operation.
// - Three one-cycle stages: multiply, add, round.
// - Status flags update at end of stage two.
// - Rounded result ready at end of stage three.
// - Clear bit restarts accumulator from product, drops hard overflow, then itself.
// - Multiply-only mode overwrites the accumulator.
// - Product in accumulator two cycles after write.
// - Multiply-only leaves hard overflow unchanged.
// - Shift command shifts once, rounds, self-clears.
// - Direction bit: zero left, one right.
// - Right shift fills from bit 39.
// - Shifts never touch status flags.
// - Round bits 31-16 to nearest even.
// - Round after stage three, shift, byte0 write.
// - Rounding never alters accumulator, any mode.
// - Saturate to 0x7FFF or 0x8000 when enabled.
// - Status shows overflow, zero and negative.
// - Accumulator five bytes, operands two bytes each.
// - Zero reads 0x04, negative reads 0x01.
`timescale 1ns/1ps
`default_nettype none
module mac_engine
  import mac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [MAC_BYTE_W-1:0] wr_data,
  input wire logic wr_a_high,
  input wire logic wr_a_low,
  input wire logic wr_b_high,
  input wire logic wr_b_low,
  input wire logic [MAC_ACC_BYTES-1:0] wr_acc_byte,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wr_data,
  input wire logic status_wr,
  input wire logic [7:0] status_wr_data,
  output logic [7:0] mac_config_reg,
  output logic [7:0] mac_status_reg,
  output logic [MAC_OP_W-1:0] operand_a,
  output logic [MAC_OP_W-1:0] operand_b,
  output logic [MAC_ACC_W-1:0] acc,
  output logic [MAC_RND_W-1:0] rounded_result,
  output logic mac_busy
);

  // Pipeline control
  logic start_pend;
  logic stage1_valid;
  logic stage2_done;
  logic shift_done;
  logic byte0_written;
  logic [MAC_PROD_W-1:0] product;
  logic product_frac;
  logic product_ms;

  // Stage two arithmetic
  logic [MAC_ACC_W-1:0] aligned_product;
  logic [MAC_ACC_W-1:0] addend;
  logic [MAC_ACC_W-1:0] next_acc_sum;
  logic add_overflow;
  logic soft_overflow;
  logic [MAC_ACC_W-1:0] stage2_value;
  logic stage2_zero;
  logic stage2_neg;
  logic busy_next;
  logic clear_now;
  logic shift_now;
  logic [MAC_ACC_W-1:0] shifted_acc;
  logic [MAC_RND_W-1:0] round_value;

  // Decoded configuration bits
  logic mode_select_bit;
  logic fractional_mode_bit;
  logic saturate_bit;
  logic clear_acc_bit;
  logic shift_direction_bit;
  logic shift_command_bit;

  assign mode_select_bit = mac_config_reg[MAC_CFG_MS_BIT];
  assign fractional_mode_bit = mac_config_reg[MAC_CFG_FM_BIT];
  assign saturate_bit = mac_config_reg[MAC_CFG_SAT_BIT];
  assign clear_acc_bit = mac_config_reg[MAC_CFG_CA_BIT];
  assign shift_direction_bit = mac_config_reg[MAC_CFG_SD_BIT];
  assign shift_command_bit = mac_config_reg[MAC_CFG_SC_BIT];

  // Clear runs in stage two, two cycles after the start write
  assign clear_now = stage1_valid && clear_acc_bit;

  // A shift waits while a stage-two add or clear owns the accumulator.
  // Without the wait the add would win and the shift bit would clear unserved.
  assign shift_now = shift_command_bit && !stage1_valid;

  // Soft overflow: value no longer fits a sign-extended 32-bit result
  function automatic logic soft_ovf_of(input logic [MAC_ACC_W-1:0] v);
    return v[MAC_ACC_W-1:MAC_PROD_W-1] != {(MAC_ACC_W-MAC_PROD_W+1){v[MAC_PROD_W-1]}};
  endfunction : soft_ovf_of

  // Operand byte registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_a <= MAC_OP_RESET;
      operand_b <= MAC_OP_RESET;
    end else begin
      if (wr_a_high) begin
        operand_a[15:8] <= wr_data;
      end
      if (wr_a_low) begin
        operand_a[7:0] <= wr_data;
      end
      if (wr_b_high) begin
        operand_b[15:8] <= wr_data;
      end
      if (wr_b_low) begin
        operand_b[7:0] <= wr_data;
      end
    end
  end

  // Start marker: the low byte of B is the only trigger
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= wr_b_low;
    end
  end

  // Stage one: signed multiply of the freshly loaded operands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      product <= 32'h0000_0000;
      product_frac <= 1'b0;
      product_ms <= 1'b0;
      stage1_valid <= 1'b0;
    end else begin
      stage1_valid <= start_pend;
      if (start_pend) begin
        product <= MAC_PROD_W'($signed(operand_a) * $signed(operand_b));
        product_frac <= fractional_mode_bit;
        product_ms <= mode_select_bit;
      end
    end
  end

  // Stage two arithmetic; the mode picks accumulator or zero as addend
  always_comb begin
    aligned_product = mac_align_product(product, product_frac);
    addend = product_ms ? MAC_ACC_RESET : acc;
    next_acc_sum = aligned_product + addend;
    add_overflow = (aligned_product[39] == addend[39]) && (next_acc_sum[39] != addend[39]);
    // A clear loads the bare product, so the flags follow that value
    stage2_value = clear_now ? aligned_product : next_acc_sum;
    soft_overflow = soft_ovf_of(stage2_value);
  end

  // Zero and sign of the value stage two is about to store
  always_comb begin
    stage2_zero = (stage2_value == MAC_ACC_RESET);
    stage2_neg = stage2_value[MAC_ACC_W-1];
  end

  // Arithmetic shift by one; right shift keeps the sign bit
  always_comb begin
    if (shift_direction_bit) begin
      shifted_acc = {acc[39], acc[39:1]};
    end else begin
      shifted_acc = {acc[38:0], 1'b0};
    end
  end

  // Stage-two completion marker, which feeds stage three
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage2_done <= 1'b0;
    end else begin
      stage2_done <= stage1_valid;
    end
  end

  // Accumulator owner priority: stage-two add, then clear, then shift, then byte writes.
  // A clear lands in the same cycle as its own add, so the bare product is loaded.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= MAC_ACC_RESET;
    end else if (stage1_valid && !clear_now) begin
      acc <= next_acc_sum;
    end else if (stage1_valid && clear_now && product_ms) begin
      acc <= aligned_product;
    end else if (stage1_valid && clear_now) begin
      acc <= aligned_product;
    end else if (shift_now) begin
      acc <= shifted_acc;
    end else begin
      for (int i = 0; i < MAC_ACC_BYTES; i++) begin
        if (wr_acc_byte[i]) begin
          acc[i*MAC_BYTE_W +: MAC_BYTE_W] <= wr_data;
        end
      end
    end
  end

  // Configuration: software writes whole byte; hardware clears the one-shot bits.
  // A fresh software write of a one-shot bit wins over the hardware clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mac_config_reg <= MAC_CFG_RESET;
    end else if (cfg_wr) begin
      mac_config_reg <= cfg_wr_data & MAC_CFG_WR_MASK;
    end else begin
      if (clear_now) begin
        mac_config_reg[MAC_CFG_CA_BIT] <= 1'b0;
      end
      if (shift_now) begin
        mac_config_reg[MAC_CFG_SC_BIT] <= 1'b0;
      end
    end
  end

  // Status flags: only multiply operations, clears and software touch them.
  // Shifts are deliberately absent, so they can never disturb a flag.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mac_status_reg <= MAC_STA_RESET;
    end else if (stage1_valid) begin
      mac_status_reg[MAC_STA_ZERO_BIT] <= stage2_zero;
      mac_status_reg[MAC_STA_NEG_BIT] <= stage2_neg;
      mac_status_reg[MAC_STA_SOFT_OVF_BIT] <= soft_overflow;
      if (clear_now) begin
        mac_status_reg[MAC_STA_HARD_OVF_BIT] <= 1'b0;
      end else if (!product_ms && add_overflow) begin
        mac_status_reg[MAC_STA_HARD_OVF_BIT] <= 1'b1;
      end else if (status_wr) begin
        mac_status_reg[MAC_STA_HARD_OVF_BIT] <= status_wr_data[MAC_STA_HARD_OVF_BIT];
      end
      mac_status_reg[7:4] <= 4'h0;
    end else if (status_wr) begin
      mac_status_reg <= {4'h0, status_wr_data[3:0]};
    end
  end

  // Markers that ask for a fresh rounding one cycle after the accumulator moved
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_done <= 1'b0;
      byte0_written <= 1'b0;
    end else begin
      shift_done <= shift_now;
      byte0_written <= wr_acc_byte[MAC_ACC_BYTE0] && !stage1_valid && !shift_now;
    end
  end

  // Rounding works from the accumulator register and only reads it
  mac_round u_round (
    .acc_in(acc),
    .saturate(saturate_bit),
    .rounded(round_value)
  );

  // Stage three: register the rounded value; the mode bit is not consulted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rounded_result <= MAC_RND_RESET;
    end else if (stage2_done || shift_done || byte0_written) begin
      rounded_result <= round_value;
    end
  end

  // Busy while any stage or a shift is outstanding; informational only
  always_comb begin
    busy_next = wr_b_low || start_pend || stage1_valid;
    busy_next = busy_next || (cfg_wr && cfg_wr_data[MAC_CFG_SC_BIT]) || (shift_command_bit && !shift_now);
  end

  // Registered so the port comes straight from a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mac_busy <= 1'b0;
    end else begin
      mac_busy <= busy_next;
    end
  end

endmodule : mac_engine
`default_nettype wire

/* File: mac_pkg.sv */
// Constants shared by the multiply-accumulate engine and its rounding stage.
// Assumes a single 200 MHz system clock and byte-wide software access strobes.
package mac_pkg;

  // Data widths
  localparam int MAC_OP_W = 16;
  localparam int MAC_ACC_W = 40;
  localparam int MAC_BYTE_W = 8;
  localparam int MAC_ACC_BYTES = 5;
  localparam int MAC_RND_W = 16;
  localparam int MAC_PROD_W = 32;

  // Configuration register field positions
  localparam int MAC_CFG_MS_BIT = 0;
  localparam int MAC_CFG_FM_BIT = 1;
  localparam int MAC_CFG_SAT_BIT = 2;
  localparam int MAC_CFG_CA_BIT = 3;
  localparam int MAC_CFG_SD_BIT = 4;
  localparam int MAC_CFG_SC_BIT = 5;
  localparam int MAC_CFG_USED_MASK_BITS = 6;

  // Status register field positions
  localparam int MAC_STA_NEG_BIT = 0;
  localparam int MAC_STA_SOFT_OVF_BIT = 1;
  localparam int MAC_STA_ZERO_BIT = 2;
  localparam int MAC_STA_HARD_OVF_BIT = 3;

  // Reset values and the configuration write mask
  localparam logic [7:0] MAC_CFG_RESET = 8'h00;
  localparam logic [7:0] MAC_STA_RESET = 8'h00;
  localparam logic [7:0] MAC_CFG_WR_MASK = 8'h3F;
  localparam logic [MAC_OP_W-1:0] MAC_OP_RESET = 16'h0000;
  localparam logic [MAC_RND_W-1:0] MAC_RND_RESET = 16'h0000;
  localparam logic [MAC_ACC_W-1:0] MAC_ACC_RESET = 40'h00_0000_0000;

  // Rounding and saturation values
  localparam logic [15:0] MAC_ROUND_HALF = 16'h8000;
  localparam logic [MAC_RND_W-1:0] MAC_SAT_POS = 16'h7FFF;
  localparam logic [MAC_RND_W-1:0] MAC_SAT_NEG = 16'h8000;

  // Timing: every pipeline stage is one clock period
  localparam int MAC_CLK_PERIOD_PS = 5000;
  localparam int MAC_STAGE_TIME_PS = 5000;
  localparam int MAC_STAGE_CYCLES = (MAC_STAGE_TIME_PS + MAC_CLK_PERIOD_PS - 1) / MAC_CLK_PERIOD_PS;
  localparam int MAC_PIPE_STAGES = 3;

  // Byte index of the accumulator byte registers
  localparam int MAC_ACC_BYTE0 = 0;
  localparam int MAC_ACC_OVR_BYTE = 4;

  // Widen a product to accumulator width, with the fractional one-bit realignment
  function automatic logic [MAC_ACC_W-1:0] mac_align_product(input logic [MAC_PROD_W-1:0] prod,
                                                             input logic frac);
    logic [MAC_ACC_W-1:0] ext;
    ext = {{(MAC_ACC_W-MAC_PROD_W){prod[MAC_PROD_W-1]}}, prod};
    if (frac) begin
      ext = {ext[MAC_ACC_W-2:0], 1'b0};
    end
    return ext;
  endfunction : mac_align_product

endpackage : mac_pkg

/* File: mac_round.sv */
// Combinational round-to-nearest-even and saturation of accumulator bits 31-16.
// Assumes the caller registers the result; it never touches the accumulator.
`timescale 1ns/1ps
`default_nettype none
module mac_round
  import mac_pkg::*;
(
  input wire logic [MAC_ACC_W-1:0] acc_in,
  input wire logic saturate,
  output logic [MAC_RND_W-1:0] rounded
);

  logic round_up;
  logic [24:0] wide_sum;
  logic fits;

  // Round up above one half, or at one half when the kept part is odd
  always_comb begin
    round_up = (acc_in[15:0] > MAC_ROUND_HALF) || ((acc_in[15:0] == MAC_ROUND_HALF) && acc_in[16]);
  end

  // Whole upper part plus increment, so overflow past 16 bits is visible
  always_comb begin
    wide_sum = {acc_in[39], acc_in[39:16]} + {24'h00_0000, round_up};
    fits = (wide_sum[24:15] == {10{wide_sum[15]}});
  end

  // Saturation applies only when requested; otherwise plain wraparound
  always_comb begin
    if (saturate && !fits) begin
      rounded = wide_sum[24] ? MAC_SAT_NEG : MAC_SAT_POS;
    end else begin
      rounded = wide_sum[15:0];
    end
  end

endmodule : mac_round
`default_nettype wire

/* File: mac_engine_props.sv */
// Checker for mac_engine: timing and value relations seen at its ports.
// Assumes one clock, clk, and a synchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module mac_engine_props
  import mac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_b_low,
  input wire logic [MAC_ACC_BYTES-1:0] wr_acc_byte,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wr_data,
  input wire logic status_wr,
  input wire logic [7:0] mac_config_reg,
  input wire logic [7:0] mac_status_reg,
  input wire logic [MAC_OP_W-1:0] operand_a,
  input wire logic [MAC_OP_W-1:0] operand_b,
  input wire logic [MAC_ACC_W-1:0] acc,
  input wire logic [MAC_RND_W-1:0] rounded_result,
  input wire logic mac_busy
);
  logic [31:0] prod_q;
  logic [31:0] prod_q2;
  logic [MAC_ACC_W-1:0] acc_q;
  logic hard_q;
  // Delayed copies, so a relation can see values from before an edge
  always_ff @(posedge clk) begin
    prod_q <= $signed(operand_a) * $signed(operand_b);
    prod_q2 <= prod_q;
    acc_q <= acc;
    hard_q <= mac_status_reg[3];
  end
  // Reference rounding; wide sum so a carry out of bit 31 is never lost
  function automatic logic [15:0] rnd_f(input logic [39:0] a, input logic s);
    logic [24:0] r;
    r = {a[39], a[39:16]} + 25'((a[15:0] > 16'h8000) || (a[15:0] == 16'h8000 && a[16]));
    if (s && r[24:15] != {10{r[24]}}) begin
      return r[24] ? MAC_SAT_NEG : MAC_SAT_POS;
    end
    return r[15:0];
  endfunction : rnd_f
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_mulonly_product: assert property (wr_b_low && mac_config_reg[0] && !mac_config_reg[1] && !cfg_wr
    |=> ##2 acc == {{8{prod_q2[31]}}, prod_q2}) else $error("multiply-only product wrong");
  a_accumulate_sum: assert property (wr_b_low && mac_config_reg[1:0] == 2'h0 && !mac_config_reg[3] && !mac_busy
    |=> ##2 acc == acc_q + {{8{prod_q2[31]}}, prod_q2}) else $error("accumulate sum wrong");
  a_status_flags: assert property (wr_b_low ##1 !wr_b_low |=> ##1
    mac_status_reg[2] == (acc == '0) && mac_status_reg[0] == acc[39]) else $error("zero or negative flag wrong");
  a_shift_left: assert property (cfg_wr && cfg_wr_data[5:4] == 2'h2 && !mac_busy
    |=> ##1 acc == {acc_q[38:0], 1'b0}) else $error("left shift wrong");
  a_shift_right: assert property (cfg_wr && cfg_wr_data[5:4] == 2'h3 && !mac_busy
    |=> ##1 acc == {acc_q[39], acc_q[39:1]}) else $error("right shift wrong");
  a_shift_selfclear: assert property ((cfg_wr && cfg_wr_data[5] && !mac_busy) ##1 !cfg_wr
    |=> !mac_config_reg[5]) else $error("shift bit stuck");
  a_shift_keeps_flags: assert property ((cfg_wr && cfg_wr_data[5] && !mac_busy) ##1 !status_wr
    |=> mac_status_reg == $past(mac_status_reg)) else $error("shift changed flags");
  a_round_pipe: assert property (wr_b_low
    |=> ##3 rounded_result == rnd_f(acc_q, mac_config_reg[2])) else $error("stage three rounding wrong");
  a_round_byte0: assert property (wr_acc_byte[0] && !mac_busy
    |=> ##1 rounded_result == rnd_f(acc_q, mac_config_reg[2])) else $error("byte write rounding wrong");
  a_hard_mulonly: assert property ((wr_b_low && mac_config_reg[0] && !mac_config_reg[3]) ##2 !status_wr
    |=> mac_status_reg[3] == hard_q) else $error("multiply-only touched hard overflow");
  a_clear_selfclear: assert property ((wr_b_low && mac_config_reg[3]) ##1 !cfg_wr [*2]
    |=> !mac_config_reg[3]) else $error("clear bit stuck");
  c_clear_op: cover property (wr_b_low && mac_config_reg[3]);
  c_right_shift: cover property (cfg_wr && cfg_wr_data[5:4] == 2'h3);
  c_saturated: cover property (mac_config_reg[2] && rounded_result == MAC_SAT_POS);
endmodule : mac_engine_props
bind mac_engine mac_engine_props i_props (.*);
`default_nettype wire

/* File: mac_engine_tb_top.sv */
// Self-checking bench for mac_engine; every scenario is its own task.
// Assumes the package, design and checker are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module mac_engine_tb_top
  import mac_pkg::*;
;
  logic clk, rst_n, wr_a_high, wr_a_low, wr_b_high, wr_b_low, cfg_wr, status_wr, mac_busy;
  logic [7:0] wr_data, cfg_wr_data, status_wr_data, mac_config_reg, mac_status_reg;
  logic [MAC_ACC_BYTES-1:0] wr_acc_byte;
  logic [MAC_OP_W-1:0] operand_a, operand_b;
  logic [MAC_RND_W-1:0] rounded_result;
  logic [MAC_ACC_W-1:0] acc;
  int n_fail, n_checks;
  // Rounding table: accumulator, saturate bit, expected rounded value
  logic [39:0] rv [8] = '{40'h00_0001_8001, 40'h00_0001_7FFF, 40'h00_0003_8000, 40'h00_0002_8000,
                          40'h00_7FFF_8000, 40'h00_7FFF_8000, 40'hFF_7FFF_0000, 40'hFF_7FFF_0000};
  logic rs [8] = '{0, 0, 0, 0, 1, 0, 1, 0};
  logic [15:0] rx [8] = '{16'h0002, 16'h0001, 16'h0004, 16'h0002, 16'h7FFF, 16'h8000, 16'h8000, 16'h7FFF};
  mac_engine i_dut (.*);
  // 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  // One-cycle strobe: 0..3 operand bytes, 4..8 accumulator bytes, 9 config
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    cfg_wr_data = d;
    {cfg_wr, wr_acc_byte, wr_b_low, wr_b_high, wr_a_low, wr_a_high} = 10'h001 << sel;
    @(negedge clk);
    {cfg_wr, wr_acc_byte, wr_b_low, wr_b_high, wr_a_low, wr_a_high} = 10'h000;
  endtask : wr
  // Byte 0 goes last, since that write also rounds
  task automatic ld(input logic [39:0] v);
    for (int i = 4; i >= 0; i--) begin
      wr(4 + i, v[8*i +: 8]);
    end
  endtask : ld
  task automatic mul(input logic [15:0] a, input logic [15:0] b);
    wr(0, a[15:8]);
    wr(1, a[7:0]);
    wr(2, b[15:8]);
    wr(3, b[7:0]);
  endtask : mul
  task automatic t_frac;
    ld(40'h12_3456_789A);
    wr(9, 8'h0A);
    mul(16'h4000, 16'h2000);
    step(2);
    chk("acc", 40'h00_1000_0000, acc);
    chk("clear bit", 1'b0, mac_config_reg[3]);
    step(1);
    chk("rounded", 16'h1000, rounded_result);
    wr(2, 8'hE0);
    wr(3, 8'h00);
    step(2);
    chk("acc", '0, acc);
    chk("status", 8'h04, mac_status_reg);
  endtask : t_frac
  task automatic t_mulonly;
    ld(40'h00_0000_0005);
    wr(9, 8'h01);
    mul(16'h1234, 16'hFEDC);
    step(1);
    chk("acc", 40'h00_0000_0005, acc);
    step(1);
    chk("acc", 40'hFF_FFEB_3CB0, acc);
    chk("status", 8'h01, mac_status_reg);
    chk("rounded", '0, rounded_result);
    step(1);
    chk("rounded", 16'hFFEB, rounded_result);
  endtask : t_mulonly
  task automatic t_shift;
    ld(40'h40_8844_2211);
    step(1);
    chk("rounded", 16'h8844, rounded_result);
    wr(9, 8'h20);
    step(1);
    chk("acc", 40'h81_1088_4422, acc);
    chk("shift bit", 1'b0, mac_config_reg[5]);
    step(1);
    chk("rounded", 16'h1088, rounded_result);
    wr(9, 8'h30);
    wr(9, 8'h30);
    step(1);
    chk("acc", 40'hE0_4422_1108, acc);
    chk("status", 8'h01, mac_status_reg);
  endtask : t_shift
  task automatic t_round;
    foreach (rv[i]) begin
      wr(9, {5'h00, rs[i], 2'h0});
      ld(rv[i]);
      step(1);
      chk("rounded", rx[i], rounded_result);
      chk("acc", rv[i], acc);
    end
  endtask : t_round
  // Overflow stays set through a multiply-only op; only the clear drops it
  task automatic t_overflow;
    wr(9, 8'h00);
    ld(40'h7F_FFFF_FFFF);
    mul(16'h0001, 16'h0001);
    step(2);
    chk("hard ovf", 1'b1, mac_status_reg[3]);
    wr(9, 8'h01);
    wr(3, 8'h01);
    step(2);
    chk("hard ovf", 1'b1, mac_status_reg[3]);
    wr(9, 8'h08);
    wr(3, 8'h01);
    step(2);
    chk("acc", 40'h00_0000_0001, acc);
    chk("status", 8'h00, mac_status_reg);
  endtask : t_overflow
  // Software clears sticky overflow; busy follows the pipeline
  task automatic t_status;
    wr(9, 8'h00);
    ld(40'h7F_FFFF_FFFF);
    mul(16'h0001, 16'h0001);
    chk("busy", 1'b1, mac_busy);
    step(2);
    chk("status", 8'h0B, mac_status_reg);
    step(1);
    chk("busy", 1'b0, mac_busy);
    chk("operand a", 16'h0001, operand_a);
    chk("operand b", 16'h0001, operand_b);
    @(negedge clk);
    status_wr_data = 8'h00;
    status_wr = 1'b1;
    @(negedge clk);
    status_wr = 1'b0;
    chk("status", 8'h00, mac_status_reg);
  endtask : t_status
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Guard against a hang
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end
  initial begin
    {wr_data, cfg_wr_data, status_wr_data, wr_acc_byte} = '0;
    {wr_a_high, wr_a_low, wr_b_high, wr_b_low, cfg_wr, status_wr} = '0;
    rst_n = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    chk("acc", '0, acc);
    chk("status", '0, mac_status_reg);
    t_frac();
    t_mulonly();
    t_shift();
    t_round();
    t_overflow();
    t_status();
    end_of_test();
  end
endmodule : mac_engine_tb_top
`default_nettype wire
